// [tcoa_pkg.sv]
// tcoa_pkg: register map, field positions and action codes of the
// timer control and compare output slice.
// assumes an 8-bit register bus with a 6-bit byte address.
`default_nettype none
package tcoa_pkg;
  localparam int AW  = 6;
  localparam int DW  = 8;
  localparam int NCH = 8;

  localparam logic [5:0] ADDR_IOS      = 6'h00;
  localparam logic [5:0] ADDR_FORCE    = 6'h01;
  localparam logic [5:0] ADDR_MASK     = 6'h02;
  localparam logic [5:0] ADDR_DATA     = 6'h03;
  localparam logic [5:0] ADDR_CNT_HI   = 6'h04;
  localparam logic [5:0] ADDR_CNT_LO   = 6'h05;
  localparam logic [5:0] ADDR_CTRL1    = 6'h06;
  localparam logic [5:0] ADDR_TOV      = 6'h07;
  localparam logic [5:0] ADDR_ACT_UP   = 6'h08;
  localparam logic [5:0] ADDR_ACT_LO   = 6'h09;
  localparam logic [5:0] ADDR_CTRL2    = 6'h0D;
  localparam logic [5:0] ADDR_CHFLG    = 6'h0E;
  localparam logic [5:0] ADDR_OVFLG    = 6'h0F;
  localparam logic [5:0] ADDR_CHV_LOW  = 6'h10;
  localparam logic [5:0] ADDR_CHV_HIGH = 6'h1F;
  localparam logic [5:0] ADDR_ACCFLG   = 6'h21;
  localparam logic [5:0] ADDR_ACC_HI   = 6'h22;
  localparam logic [5:0] ADDR_ACC_LO   = 6'h23;
  localparam logic [5:0] ADDR_PPS      = 6'h2E;
  localparam logic [5:0] ADDR_DISC     = 6'h30;
  localparam logic [5:0] ADDR_PINS     = 6'h31;

  localparam int CHV_IDX_LSB  = 1;
  localparam int CHV_IDX_MSB  = 3;
  localparam int ON_BIT       = 7;
  localparam int WAIT_BIT     = 6;
  localparam int FRZ_BIT      = 5;
  localparam int FFC_BIT      = 4;
  localparam int PRECISION_SELECT_BIT     = 3;
  localparam int PR_MSB       = 2;
  localparam int OVF_BIT      = 7;
  localparam int ACC_OVF_BIT  = 1;
  localparam int ACC_EDGE_BIT = 0;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_LOW    = 2'b10,
    ACT_HIGH   = 2'b11
  } tcoa_act_t;
endpackage
`default_nettype wire

// [tcoa_sync.sv]
// tcoa_sync: two-flop synchroniser for pin levels.
// assumes the inputs are asynchronous levels, not pulses.
`default_nettype none
module tcoa_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// [tcoa_out.sv]
// tcoa_out: per-channel compare output latch and pin drive enable.
// assumes events are single-cycle pulses on the bus clock.
`default_nettype none
module tcoa_out #(
  parameter int N = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [N-1:0] ios,
  input  wire logic [N-1:0] mask,
  input  wire logic [N-1:0] data,
  input  wire logic [N-1:0] disc,
  input  wire logic [N-1:0] toggle_on_overflow_bit,
  input  wire logic [N-1:0] act_m,
  input  wire logic [N-1:0] act_l,
  input  wire logic         ch7_evt,
  input  wire logic         ovf_evt,
  input  wire logic [N-1:0] match,
  input  wire logic [N-1:0] force_evt,
  output var  logic [N-1:0] pin_o,
  output var  logic [N-1:0] pin_oe_b
);
  logic [N-1:0] nxt_out;
  logic [N-1:0] nxt_oe_b;

  function automatic logic apply_act(input logic cur, input tcoa_pkg::tcoa_act_t code);
    case (code)
      tcoa_pkg::ACT_TOGGLE: apply_act = ~cur;
      tcoa_pkg::ACT_LOW:    apply_act = 1'b0;
      tcoa_pkg::ACT_HIGH:   apply_act = 1'b1;
      default:              apply_act = cur;
    endcase
  endfunction

  // later assignments win: compare first, then toggle, then channel 7 override
  always_comb begin
    for (int i = 0; i < N; i++) begin
      nxt_out[i] = pin_o[i];
      if (ios[i]) begin
        if (match[i] || force_evt[i]) begin
          nxt_out[i] = apply_act(pin_o[i], tcoa_pkg::tcoa_act_t'({act_m[i], act_l[i]}));
        end
        if (ovf_evt && toggle_on_overflow_bit[i]) begin
          nxt_out[i] = ~pin_o[i];
        end
        if (ch7_evt && mask[i]) begin
          nxt_out[i] = data[i];
        end
      end
    end
  end

  // masked channels drive too, so the channel 7 data can reach the pin
  always_comb begin
    for (int i = 0; i < N; i++) begin
      nxt_oe_b[i] = ~(ios[i] & ~disc[i] & (act_m[i] | act_l[i] | mask[i]));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_o    <= '0;
      pin_oe_b <= '1;
    end else begin
      pin_o    <= nxt_out;
      pin_oe_b <= nxt_oe_b;
    end
  end
endmodule
`default_nettype wire

// [tcoa_top.sv]
// tcoa_top: timer enable, stop controls, fast flag clearing, prescaler
// choice, toggle on overflow and compare output actions of 8 channels.
// assumes counter, comparators, capture edge logic and accumulator sit
// outside on SYS_CLK and hand in single-cycle event pulses.
//
// Overview of operation
// - timer off halts timer and counter
// - divide-by-64 clock only while timer active
// - wait stop halts timer and accumulator
// - freeze stop halts counter, not accumulator
// - fast clear: capture read or compare write clears flag
// - fast clear: counter access clears overflow flag
// - fast clear: accumulator access clears its flags
// - precision bit picks precision or legacy prescale
// - precision bit writable once after reset
// - toggle output on overflow in compare mode
// - toggle beats force, loses to channel 7
// - action code: none, toggle, low, high
// - nonzero action code makes a connected compare pin output
// - mask adds channel 7 data on top of own action
// - channel 7 masked takes data; others both
// - normal clear: write one while enabled
`default_nettype none
module tcoa_top #(
  parameter int NCH = tcoa_pkg::NCH
) (
  input  wire logic                    SYS_CLK,
  input  wire logic                    RST_B,
  input  wire logic [tcoa_pkg::AW-1:0] BUS_ADDR,
  input  wire logic [tcoa_pkg::DW-1:0] BUS_WDATA,
  input  wire logic                    BUS_WR,
  input  wire logic                    BUS_RD,
  output var  logic [tcoa_pkg::DW-1:0] BUS_RDATA,
  input  wire logic                    CPU_WAIT,
  input  wire logic                    CPU_FREEZE,
  input  wire logic                    ACCUM_ON,
  input  wire logic                    CNT_OVF,
  input  wire logic [NCH-1:0]          CMP_MATCH,
  input  wire logic [NCH-1:0]          CAPTURE_EVT,
  input  wire logic                    ACC_OVF_EVT,
  input  wire logic                    ACC_EDGE_EVT,
  input  wire logic [NCH-1:0]          CHAN_PIN_I,
  output var  logic [NCH-1:0]          CHAN_PIN_O,
  output var  logic [NCH-1:0]          CHAN_PIN_OE_B,
  output var  logic                    TIMER_ACTIVE,
  output var  logic                    COUNTER_RUN,
  output var  logic                    ACCUM_RUN,
  output var  logic                    ACCUM_DIV64_EN,
  output var  logic                    PRESCALE_PRECISE,
  output var  logic [7:0]              PRESCALE_DIV_M1,
  output var  logic [NCH-1:0]          CHAN_FLAGS,
  output var  logic                    OVF_FLAG,
  output var  logic [1:0]              ACC_FLAGS
);

  // control registers
  logic [NCH-1:0] ios_ff;
  logic [NCH-1:0] mask_ff;
  logic [NCH-1:0] data_ff;
  logic [NCH-1:0] disc_ff;
  logic [NCH-1:0] tov_ff;
  logic [7:0]     act_up_ff;
  logic [7:0]     act_lo_ff;
  logic [2:0]     pr_ff;
  logic [7:0]     pps_ff;
  logic           timer_on_ff;
  logic           stop_in_wait_ff;
  logic           stop_in_freeze_ff;
  logic           fast_flag_clear_ff;
  logic           precision_select_ff;
  logic           prec_locked_ff;

  // flags and bus answer
  logic [NCH-1:0] chflg_ff;
  logic           ovflg_ff;
  logic [1:0]     accflg_ff;
  logic [7:0]     rdata_ff;
  logic [NCH-1:0] force_ff;

  // derived
  logic [NCH-1:0] pins_sync;
  logic [NCH-1:0] act_m;
  logic [NCH-1:0] act_l;
  logic [NCH-1:0] nxt_chflg;
  logic [NCH-1:0] ch_set;
  logic [NCH-1:0] ch_clr;
  logic [NCH-1:0] fast_ch;
  logic [NCH-1:0] match_q;
  logic [7:0]     nxt_rdata;
  logic [2:0]     chv_idx;
  logic           nxt_ovflg;
  logic [1:0]     nxt_accflg;
  logic           clr_allowed;
  logic           chv_hit;
  logic           cnt_hit;
  logic           acc_hit;
  logic           ovf_q;
  logic           ch7_evt;
  logic           nxt_active;

  function automatic logic [7:0] legacy_div_m1(input logic [2:0] pr);
    legacy_div_m1 = 8'((tcoa_pkg::ONE_BYTE << pr) - tcoa_pkg::ONE_BYTE);
  endfunction

  function automatic logic wr_at(input logic [5:0] a);
    wr_at = BUS_WR && (BUS_ADDR == a);
  endfunction

  tcoa_sync #(
    .W (NCH)
  ) u_pin_sync (
    .clk   (SYS_CLK),
    .rst_b (RST_B),
    .d     (CHAN_PIN_I),
    .q     (pins_sync)
  );

  // register writes; everything clears on reset
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ios_ff    <= tcoa_pkg::RST_BYTE;
      mask_ff   <= tcoa_pkg::RST_BYTE;
      data_ff   <= tcoa_pkg::RST_BYTE;
      disc_ff   <= tcoa_pkg::RST_BYTE;
      tov_ff    <= tcoa_pkg::RST_BYTE;
      act_up_ff <= tcoa_pkg::RST_BYTE;
      act_lo_ff <= tcoa_pkg::RST_BYTE;
      pr_ff     <= 3'h0;
      pps_ff    <= tcoa_pkg::RST_BYTE;
    end else begin
      if (wr_at(tcoa_pkg::ADDR_IOS)) begin
        ios_ff <= BUS_WDATA;
      end
      if (wr_at(tcoa_pkg::ADDR_MASK)) begin
        mask_ff <= BUS_WDATA;
      end
      if (wr_at(tcoa_pkg::ADDR_DATA)) begin
        data_ff <= BUS_WDATA;
      end
      if (wr_at(tcoa_pkg::ADDR_DISC)) begin
        disc_ff <= BUS_WDATA;
      end
      if (wr_at(tcoa_pkg::ADDR_TOV)) begin
        tov_ff <= BUS_WDATA;
      end
      if (wr_at(tcoa_pkg::ADDR_ACT_UP)) begin
        act_up_ff <= BUS_WDATA;
      end
      if (wr_at(tcoa_pkg::ADDR_ACT_LO)) begin
        act_lo_ff <= BUS_WDATA;
      end
      if (wr_at(tcoa_pkg::ADDR_CTRL2)) begin
        pr_ff <= BUS_WDATA[tcoa_pkg::PR_MSB:0];
      end
      if (wr_at(tcoa_pkg::ADDR_PPS)) begin
        pps_ff <= BUS_WDATA;
      end
    end
  end

  // system control one; the precision bit takes only the first write
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      timer_on_ff         <= 1'b0;
      stop_in_wait_ff     <= 1'b0;
      stop_in_freeze_ff   <= 1'b0;
      fast_flag_clear_ff  <= 1'b0;
      precision_select_ff <= 1'b0;
      prec_locked_ff      <= 1'b0;
    end else if (wr_at(tcoa_pkg::ADDR_CTRL1)) begin
      timer_on_ff        <= BUS_WDATA[tcoa_pkg::ON_BIT];
      stop_in_wait_ff    <= BUS_WDATA[tcoa_pkg::WAIT_BIT];
      stop_in_freeze_ff  <= BUS_WDATA[tcoa_pkg::FRZ_BIT];
      fast_flag_clear_ff <= BUS_WDATA[tcoa_pkg::FFC_BIT];
      prec_locked_ff     <= 1'b1;
      if (!prec_locked_ff) begin
        precision_select_ff <= BUS_WDATA[tcoa_pkg::PRECISION_SELECT_BIT];
      end
    end
  end

  // forced compare is a one-cycle strobe, reads back as zero
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      force_ff <= tcoa_pkg::RST_BYTE;
    end else if (wr_at(tcoa_pkg::ADDR_FORCE)) begin
      force_ff <= BUS_WDATA;
    end else begin
      force_ff <= tcoa_pkg::RST_BYTE;
    end
  end

  // run controls feed counter, prescaler and accumulator outside
  assign nxt_active = timer_on_ff & ~(CPU_WAIT & stop_in_wait_ff);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      TIMER_ACTIVE     <= 1'b0;
      COUNTER_RUN      <= 1'b0;
      ACCUM_RUN        <= 1'b0;
      ACCUM_DIV64_EN   <= 1'b0;
      PRESCALE_PRECISE <= 1'b0;
      PRESCALE_DIV_M1  <= tcoa_pkg::RST_BYTE;
    end else begin
      TIMER_ACTIVE     <= nxt_active;
      COUNTER_RUN      <= nxt_active & ~(CPU_FREEZE & stop_in_freeze_ff);
      ACCUM_RUN        <= ACCUM_ON & ~(CPU_WAIT & stop_in_wait_ff);
      ACCUM_DIV64_EN   <= nxt_active;
      PRESCALE_PRECISE <= precision_select_ff;
      PRESCALE_DIV_M1  <= precision_select_ff ? pps_ff : legacy_div_m1(pr_ff);
    end
  end

  // action code pairs: upper byte holds channels 7..4, two bits each
  always_comb begin
    for (int i = 0; i < NCH / 2; i++) begin
      act_m[i + 4] = act_up_ff[2 * i + 1];
      act_l[i + 4] = act_up_ff[2 * i];
      act_m[i]     = act_lo_ff[2 * i + 1];
      act_l[i]     = act_lo_ff[2 * i];
    end
  end

  // match and overflow events only count while the counter runs; a halted counter is silent
  assign match_q = CMP_MATCH & {NCH{COUNTER_RUN}};
  assign ovf_q   = CNT_OVF & COUNTER_RUN;
  assign ch7_evt = (match_q[NCH-1] | (ovf_q & tov_ff[NCH-1])) & ios_ff[NCH-1];

  tcoa_out #(
    .N (NCH)
  ) u_out (
    .clk       (SYS_CLK),
    .rst_b     (RST_B),
    .ios       (ios_ff),
    .mask      (mask_ff),
    .data      (data_ff),
    .disc      (disc_ff),
    .toggle_on_overflow_bit       (tov_ff),
    .act_m     (act_m),
    .act_l     (act_l),
    .ch7_evt   (ch7_evt),
    .ovf_evt   (ovf_q),
    .match     (match_q),
    .force_evt (force_ff),
    .pin_o     (CHAN_PIN_O),
    .pin_oe_b  (CHAN_PIN_OE_B)
  );

  // address classes for fast clearing
  assign chv_idx = BUS_ADDR[tcoa_pkg::CHV_IDX_MSB:tcoa_pkg::CHV_IDX_LSB];
  assign chv_hit = (BUS_ADDR >= tcoa_pkg::ADDR_CHV_LOW) && (BUS_ADDR <= tcoa_pkg::ADDR_CHV_HIGH);
  assign cnt_hit = (BUS_ADDR == tcoa_pkg::ADDR_CNT_HI) || (BUS_ADDR == tcoa_pkg::ADDR_CNT_LO);
  assign acc_hit = (BUS_ADDR == tcoa_pkg::ADDR_ACC_HI) || (BUS_ADDR == tcoa_pkg::ADDR_ACC_LO);
  assign clr_allowed = timer_on_ff | ACCUM_ON;

  // capture channels clear on read, compare channels on write
  always_comb begin
    fast_ch = '0;
    if (fast_flag_clear_ff && chv_hit) begin
      if (BUS_RD && !ios_ff[chv_idx]) begin
        fast_ch[chv_idx] = 1'b1;
      end
      if (BUS_WR && ios_ff[chv_idx]) begin
        fast_ch[chv_idx] = 1'b1;
      end
    end
  end

  // a forced compare does not raise the flag
  assign ch_set = (match_q & ios_ff & ~force_ff) | (CAPTURE_EVT & ~ios_ff);
  assign ch_clr = (wr_at(tcoa_pkg::ADDR_CHFLG) && clr_allowed) ? BUS_WDATA : '0;

  // set wins over any clear in the same cycle
  assign nxt_chflg = (chflg_ff & ~(ch_clr | fast_ch)) | ch_set;

  always_comb begin
    nxt_ovflg = ovflg_ff;
    if (wr_at(tcoa_pkg::ADDR_OVFLG) && clr_allowed && BUS_WDATA[tcoa_pkg::OVF_BIT]) begin
      nxt_ovflg = 1'b0;
    end
    if (fast_flag_clear_ff && cnt_hit && (BUS_RD || BUS_WR)) begin
      nxt_ovflg = 1'b0;
    end
    if (ovf_q) begin
      nxt_ovflg = 1'b1;
    end
  end

  always_comb begin
    nxt_accflg = accflg_ff;
    if (wr_at(tcoa_pkg::ADDR_ACCFLG) && clr_allowed) begin
      nxt_accflg = accflg_ff & ~BUS_WDATA[tcoa_pkg::ACC_OVF_BIT:tcoa_pkg::ACC_EDGE_BIT];
    end
    if (fast_flag_clear_ff && acc_hit && (BUS_RD || BUS_WR)) begin
      nxt_accflg = 2'h0;
    end
    if (ACC_OVF_EVT) begin
      nxt_accflg[tcoa_pkg::ACC_OVF_BIT] = 1'b1;
    end
    if (ACC_EDGE_EVT) begin
      nxt_accflg[tcoa_pkg::ACC_EDGE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      chflg_ff  <= tcoa_pkg::RST_BYTE;
      ovflg_ff  <= 1'b0;
      accflg_ff <= 2'h0;
    end else begin
      chflg_ff  <= nxt_chflg;
      ovflg_ff  <= nxt_ovflg;
      accflg_ff <= nxt_accflg;
    end
  end

  assign CHAN_FLAGS = chflg_ff;
  assign OVF_FLAG   = ovflg_ff;
  assign ACC_FLAGS  = accflg_ff;

  // read mux; unmapped and foreign addresses answer zero
  always_comb begin
    nxt_rdata = tcoa_pkg::RST_BYTE;
    if (BUS_RD) begin
      case (BUS_ADDR)
        tcoa_pkg::ADDR_IOS:    nxt_rdata = ios_ff;
        tcoa_pkg::ADDR_MASK:   nxt_rdata = mask_ff;
        tcoa_pkg::ADDR_DATA:   nxt_rdata = data_ff;
        tcoa_pkg::ADDR_CTRL1: begin
          nxt_rdata = tcoa_pkg::RST_BYTE;
          nxt_rdata[tcoa_pkg::ON_BIT]   = timer_on_ff;
          nxt_rdata[tcoa_pkg::WAIT_BIT] = stop_in_wait_ff;
          nxt_rdata[tcoa_pkg::FRZ_BIT]  = stop_in_freeze_ff;
          nxt_rdata[tcoa_pkg::FFC_BIT]  = fast_flag_clear_ff;
          nxt_rdata[tcoa_pkg::PRECISION_SELECT_BIT] = precision_select_ff;
        end
        tcoa_pkg::ADDR_TOV:    nxt_rdata = tov_ff;
        tcoa_pkg::ADDR_ACT_UP: nxt_rdata = act_up_ff;
        tcoa_pkg::ADDR_ACT_LO: nxt_rdata = act_lo_ff;
        tcoa_pkg::ADDR_CTRL2:  nxt_rdata = {5'h00, pr_ff};
        tcoa_pkg::ADDR_CHFLG:  nxt_rdata = chflg_ff;
        tcoa_pkg::ADDR_OVFLG: begin
          nxt_rdata = tcoa_pkg::RST_BYTE;
          nxt_rdata[tcoa_pkg::OVF_BIT] = ovflg_ff;
        end
        tcoa_pkg::ADDR_ACCFLG: nxt_rdata = {6'h00, accflg_ff};
        tcoa_pkg::ADDR_PPS:    nxt_rdata = pps_ff;
        tcoa_pkg::ADDR_DISC:   nxt_rdata = disc_ff;
        tcoa_pkg::ADDR_PINS:   nxt_rdata = pins_sync;
        default:               nxt_rdata = tcoa_pkg::RST_BYTE;
      endcase
    end
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      rdata_ff <= tcoa_pkg::RST_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign BUS_RDATA = rdata_ff;

endmodule
`default_nettype wire

// [tcoa_top_asserts.sv]
// tcoa_top_asserts: port-level checks for the timer control slice.
// assumes it is bound to tcoa_top; one clock, synchronous active-low reset.
`default_nettype none
module tcoa_top_asserts #(
  parameter int NCH = 8
) (
  input wire logic                    SYS_CLK,
  input wire logic                    RST_B,
  input wire logic [tcoa_pkg::AW-1:0] BUS_ADDR,
  input wire logic [tcoa_pkg::DW-1:0] BUS_WDATA,
  input wire logic                    BUS_WR,
  input wire logic                    BUS_RD,
  input wire logic                    CPU_WAIT,
  input wire logic                    CPU_FREEZE,
  input wire logic                    CNT_OVF,
  input wire logic [NCH-1:0]          CHAN_PIN_OE_B,
  input wire logic                    TIMER_ACTIVE,
  input wire logic                    COUNTER_RUN,
  input wire logic                    ACCUM_DIV64_EN,
  input wire logic                    PRESCALE_PRECISE,
  input wire logic                    OVF_FLAG
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  logic [7:0] ctl_ff;
  logic       lock_ff;
  logic       cnt_acc;
  // shadow of the control byte, only to judge the outputs
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ctl_ff  <= 8'h00;
      lock_ff <= 1'b0;
    end else if (BUS_WR && BUS_ADDR == 6'h06) begin
      ctl_ff  <= BUS_WDATA;
      lock_ff <= 1'b1;
    end
  end
  assign cnt_acc = (BUS_WR || BUS_RD) && (BUS_ADDR == 6'h04 || BUS_ADDR == 6'h05);
  timer_off_a: assert property (!ctl_ff[7] |=> !TIMER_ACTIVE && !COUNTER_RUN)
    else $error("timer runs while disabled");
  timer_runs_a: assert property (ctl_ff[7] && !(ctl_ff[6] && CPU_WAIT)
    && !(ctl_ff[5] && CPU_FREEZE) |=> TIMER_ACTIVE && COUNTER_RUN)
    else $error("enabled timer not running");
  div64_follow_a: assert property ((ACCUM_DIV64_EN == TIMER_ACTIVE) and
    (!ctl_ff[7] || (ctl_ff[6] && CPU_WAIT) |=> !ACCUM_DIV64_EN))
    else $error("divide by 64 clock without active timer");
  wait_stop_a: assert property (ctl_ff[7] && ctl_ff[6] && CPU_WAIT
    |=> !TIMER_ACTIVE && !COUNTER_RUN)
    else $error("timer runs in wait with stop set");
  freeze_stop_a: assert property (ctl_ff[7] && ctl_ff[5] && CPU_FREEZE
    && !(ctl_ff[6] && CPU_WAIT) |=> TIMER_ACTIVE && !COUNTER_RUN)
    else $error("freeze stop handled wrongly");
  ovf_fast_clr_a: assert property (ctl_ff[4] && cnt_acc && !CNT_OVF |=> !OVF_FLAG)
    else $error("counter access left overflow flag set");
  prec_lock_a: assert property (lock_ff [*3] |-> $stable(PRESCALE_PRECISE))
    else $error("precision select changed after lock");
  reset_state_a: assert property (disable iff (1'b0) !RST_B |=> &CHAN_PIN_OE_B
    && !TIMER_ACTIVE && !COUNTER_RUN && !PRESCALE_PRECISE && !OVF_FLAG)
    else $error("reset state wrong");
  wait_stop_c: cover property (ctl_ff[6] && CPU_WAIT);
  freeze_stop_c: cover property (ctl_ff[5] && CPU_FREEZE);
  fast_clear_c: cover property (ctl_ff[4] && cnt_acc && OVF_FLAG);
endmodule
`default_nettype wire

// [tcoa_pin_model.sv]
// tcoa_pin_model: what stands on the eight channel pins outside the block.
// assumes the block drives a pin while its enable is low; no pull resistors.
`default_nettype none
module tcoa_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_b,
  input  wire logic [7:0] ext_drv,
  input  wire logic [7:0] ext_val,
  output var  logic [7:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_ff = 8'h00;
  // floating pins wander so no stale level can pass for a drive
  always_ff @(posedge clk) float_ff <= ~pin_i;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_b[i])
        pin_i[i] = pin_o[i];
      else if (ext_drv[i])
        pin_i[i] = ext_val[i];
      else
        pin_i[i] = float_ff[i];
    end
  end
endmodule
`default_nettype wire

// [timer_control_output_compare_action_tb.sv]
// timer_control_output_compare_action_tb: self-checking bench of tcoa_top.
// assumes tcoa_pin_model on the pins; ch5 pin held high from outside.
`default_nettype none
module timer_control_output_compare_action_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       cwait = 1'b0;
  logic       cfrz = 1'b0;
  logic       acc_on = 1'b1;
  logic       ovf = 1'b0;
  logic [7:0] match = 8'h00;
  logic [7:0] capt = 8'h00;
  logic       a_ovf = 1'b0;
  logic       a_edge = 1'b0;
  logic [7:0] rdata, pin_i, pin_o, oe_b, div, cfl, d;
  logic       act, crun, arun, d64, prec, ofl;
  logic [1:0] afl;
  int         err_count = 0;
  int         n_compared = 0;
  always #25 clk = ~clk;
  tcoa_top tcoa_top_i (
    .SYS_CLK(clk), .RST_B(rst_b), .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_WR(wr),
    .BUS_RD(rd), .BUS_RDATA(rdata), .CPU_WAIT(cwait), .CPU_FREEZE(cfrz),
    .ACCUM_ON(acc_on), .CNT_OVF(ovf), .CMP_MATCH(match), .CAPTURE_EVT(capt),
    .ACC_OVF_EVT(a_ovf), .ACC_EDGE_EVT(a_edge), .CHAN_PIN_I(pin_i), .CHAN_PIN_O(pin_o),
    .CHAN_PIN_OE_B(oe_b), .TIMER_ACTIVE(act), .COUNTER_RUN(crun), .ACCUM_RUN(arun),
    .ACCUM_DIV64_EN(d64), .PRESCALE_PRECISE(prec), .PRESCALE_DIV_M1(div),
    .CHAN_FLAGS(cfl), .OVF_FLAG(ofl), .ACC_FLAGS(afl));
  tcoa_pin_model tcoa_pin_model_i (
    .clk(clk), .pin_o(pin_o), .pin_oe_b(oe_b), .ext_drv(8'h20), .ext_val(8'h20),
    .pin_i(pin_i));
  function automatic logic [7:0] st();
    return {5'h00, act, crun, d64};
  endfunction
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrr(logic [5:0] a, logic [7:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdv(logic [5:0] a, output logic [7:0] v);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rdc(logic [5:0] a, logic [7:0] e);
    logic [7:0] v;
    rdv(a, v);
    chk("rdata", v, e);
  endtask
  task automatic hit(logic [7:0] m, logic o);
    @(posedge clk);
    match <= m;
    ovf   <= o;
    @(posedge clk);
    match <= 8'h00;
    ovf   <= 1'b0;
    #1;
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    step(1);
  endtask
  task automatic t_reset;
    chk("oe_b", oe_b, 8'hFF);
    chk("status", st(), 8'h00);
    for (int a = 6; a < 10; a++) rdc(6'(a), 8'h00);
    rdc(6'h3F, 8'h00);
  endtask
  task automatic t_prec;
    wrr(6'h2E, 8'h5A);
    wrr(6'h06, 8'h08);
    wrr(6'h06, 8'h80);
    step(2);
    chk("precise", {7'h00, prec}, 8'h01);
    chk("div", div, 8'h5A);
    rdc(6'h06, 8'h88);
    do_reset();
    wrr(6'h0D, 8'h03);
    wrr(6'h06, 8'h80);
    wrr(6'h06, 8'h88);
    step(2);
    chk("precise", {7'h00, prec}, 8'h00);
    chk("div", div, 8'h07);
  endtask
  task automatic t_run;
    chk("status", st(), 8'h07);
    wrr(6'h06, 8'h00);
    step(2);
    chk("status", st(), 8'h00);
    wrr(6'h06, 8'hE0);
    cwait <= 1'b1;
    step(2);
    chk("status", st(), 8'h00);
    chk("accum", {7'h00, arun}, 8'h00);
    @(posedge clk);
    cwait <= 1'b0;
    cfrz  <= 1'b1;
    step(2);
    chk("status", st(), 8'h05);
    chk("accum", {7'h00, arun}, 8'h01);
    wrr(6'h06, 8'h80);
    step(2);
    chk("status", st(), 8'h07);
    @(posedge clk);
    cfrz <= 1'b0;
  endtask
  task automatic t_act;
    wrr(6'h00, 8'hDF);
    wrr(6'h09, 8'h39);
    wrr(6'h08, 8'h03);
    wrr(6'h30, 8'h10); // only ch4 cut off
    step(2);
    chk("oe_b", oe_b, 8'hF8);
    hit(8'h1F, 1'b0);
    chk("pin_o", pin_o, 8'h15);
    chk("flags", cfl, 8'h1F);
    hit(8'h01, 1'b0);
    chk("pin_o", pin_o, 8'h14);
    step(3);
    rdv(6'h31, d);
    chk("pins", d & 8'h27, 8'h24);
  endtask
  task automatic t_tov;
    wrr(6'h07, 8'h22);
    wrr(6'h01, 8'h02);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    step(1);
    chk("pin_o", pin_o, 8'h16);
    hit(8'h00, 1'b1);
    chk("pin_o", pin_o, 8'h14);
  endtask
  task automatic t_mask;
    wrr(6'h02, 8'h03); // ch7 own code stays in charge
    wrr(6'h03, 8'h03);
    wrr(6'h08, 8'hC3);
    hit(8'h80, 1'b0);
    chk("pin_o", pin_o, 8'h97);
    wrr(6'h02, 8'h82);
    wrr(6'h03, 8'h02);
    hit(8'h02, 1'b0);
    chk("pin_o", pin_o, 8'h95);
    hit(8'h80, 1'b0);
    chk("pin_o", pin_o, 8'h17);
    hit(8'h82, 1'b0);
    chk("pin_o", pin_o, 8'h17);
  endtask
  task automatic t_flag;
    wrr(6'h0E, 8'h01);
    step(1);
    chk("flags", cfl, 8'h9E);
    wrr(6'h06, 8'h00);
    acc_on <= 1'b0;
    wrr(6'h0E, 8'h02);
    step(1);
    chk("flags", cfl, 8'h9E);
    wrr(6'h06, 8'h90);
    acc_on <= 1'b1;
    wrr(6'h12, 8'h00);
    step(1);
    chk("flags", cfl, 8'h9C);
    rdv(6'h14, d);
    step(1);
    chk("flags", cfl, 8'h9C);
    @(posedge clk);
    capt <= 8'h20;
    @(posedge clk);
    capt <= 8'h00;
    #1 chk("flags", cfl, 8'hBC);
    rdv(6'h1A, d);
    step(1);
    chk("flags", cfl, 8'h9C);
    chk("ovf", {7'h00, ofl}, 8'h01);
    rdv(6'h05, d);
    step(1);
    chk("ovf", {7'h00, ofl}, 8'h00);
    @(posedge clk);
    a_ovf  <= 1'b1;
    a_edge <= 1'b1;
    @(posedge clk);
    a_ovf  <= 1'b0;
    a_edge <= 1'b0;
    #1 chk("acc", {6'h00, afl}, 8'h03);
    wrr(6'h22, 8'h00);
    step(1);
    chk("acc", {6'h00, afl}, 8'h00);
  endtask
  task automatic t_acc;
    wrr(6'h02, 8'h00); // ch7 mask bit cleared
    wrr(6'h08, 8'h03); // ch7 code zero
    wrr(6'h09, 8'h38); // ch0 code zero
    step(2);
    chk("oe_b", oe_b & 8'h81, 8'h81);
    chk("accum", {7'h00, arun}, 8'h01);
    hit(8'h81, 1'b0);
    chk("pin_o", pin_o, 8'h17);
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    do_reset();
    t_reset();
    t_prec();
    t_run();
    t_act();
    t_tov();
    t_mask();
    t_flag();
    t_acc();
    report_and_stop();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
bind tcoa_top tcoa_top_asserts #(.NCH(NCH)) tcoa_top_asserts_i (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
  .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .CPU_WAIT(CPU_WAIT), .CPU_FREEZE(CPU_FREEZE),
  .CNT_OVF(CNT_OVF), .CHAN_PIN_OE_B(CHAN_PIN_OE_B), .TIMER_ACTIVE(TIMER_ACTIVE),
  .COUNTER_RUN(COUNTER_RUN), .ACCUM_DIV64_EN(ACCUM_DIV64_EN),
  .PRESCALE_PRECISE(PRESCALE_PRECISE), .OVF_FLAG(OVF_FLAG));
`default_nettype wire
